// ==== rtl/wmhp_pkg.sv ====
// Shared constants for the wireless module host port
package wmhp_pkg;
    // -------------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned SETTLE_US         = 1000;   // Settle after power-off release
    localparam int unsigned RESET_REL_MS      = 300;    // Reset release allowance
    localparam int unsigned SETTLE_CYC        = CLK_HZ / 1_000_000 * SETTLE_US;
    localparam int unsigned RESET_REL_CYC     = CLK_HZ / 1000 * RESET_REL_MS;
    localparam int unsigned SCK_MAX_HZ        = 25_000_000;
    localparam int unsigned SCK_HALF_MIN      = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
    localparam int unsigned SYNC_LAT_CYC      = 4;      // Pin change to decision inside one end
    // Half period must cover a synchroniser round trip, so the clock runs below its ceiling
    localparam int unsigned SCK_HALF_CYC      = (2 * SYNC_LAT_CYC + 1 > SCK_HALF_MIN)
                                              ? 2 * SYNC_LAT_CYC + 1 : SCK_HALF_MIN;
    localparam int unsigned BAUD              = 19200;
    localparam int unsigned BAUD_CYC          = CLK_HZ / BAUD;
    localparam int unsigned DATA_BITS         = 8;
    localparam int unsigned FIFO_DEPTH        = 4;
    localparam int unsigned CNT_W             = 32;
    localparam logic [7:0]  BYTE_IDLE         = 8'h00;  // Byte shifted out when queue empty
    localparam logic [2:0]  BIT_TOP           = 3'h7;
endpackage

// ==== rtl/wmhp_if.sv ====
// Pin bundle between the host controller and the wireless module
`timescale 1ns/100ps
interface wmhp_if;
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic irq_n_oe_n;                 // Open drain: low enable pulls the line low
    logic irq_n;
    logic power_off_req;
    logic module_reset_n;
    logic scan_enable;
    logic boundary_scan_reset;
    logic diag_uart_tx;
    logic diag_uart_rx;

    // Pull-up on the interrupt line
    assign irq_n = irq_n_oe_n;

    modport device (
        input  cs_n, sck, sdi, power_off_req, module_reset_n,
        input  scan_enable, boundary_scan_reset, diag_uart_rx,
        output sdo, sdo_oe_n, irq_n_oe_n, diag_uart_tx
    );
    modport host (
        output cs_n, sck, sdi, power_off_req, module_reset_n,
        output scan_enable, boundary_scan_reset, diag_uart_rx,
        input  sdo, sdo_oe_n, irq_n, diag_uart_tx
    );
endinterface

// ==== rtl/wmhp_fifo.sv ====
// Small valid/ready FIFO for byte streams
`timescale 1ns/100ps
module wmhp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
    } wmhp_fifo_s;

    logic [WIDTH-1:0] mem_r [DEPTH];
    wmhp_fifo_s       st_r;
    wmhp_fifo_s       st_nxt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (st_r.count != (AW+1)'(DEPTH));
    assign out_valid_o = (st_r.count != '0);
    assign out_data_o  = mem_r[st_r.rptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointer and occupancy update
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.wptr = (st_r.wptr == AW'(DEPTH - 1)) ? '0 : st_r.wptr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rptr = (st_r.rptr == AW'(DEPTH - 1)) ? '0 : st_r.rptr + 1'b1;
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Storage has no reset; contents are only read once written
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_r[st_r.wptr] <= in_data_i;
        end
    end
endmodule

// ==== rtl/wmhp_device.sv ====
// Wireless module end: SPI slave, data-available interrupt, power states, diag UART
`timescale 1ns/100ps
module wmhp_device (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       supply_good_i,     // Supply within range
    // Host pins
    wmhp_if.device          pins,
    // Radio side
    input  wire logic       rx_valid_i,        // Received byte for the host
    input  wire logic [7:0] rx_data_i,
    output logic            rx_ready_o,        // Back-pressure to the radio
    output logic            tx_valid_o,        // Byte written by the host
    output logic [7:0]      tx_data_o,
    input  wire logic       power_save_en_i,   // Sleep power save enabled
    input  wire logic       beacon_tick_i,     // Beacon interval pulse
    input  wire logic       traffic_queued_i,  // Beacon lists traffic
    input  wire logic       radio_busy_i,      // Activity pending
    input  wire logic       tx_active_i,       // Radio is transmitting
    input  wire logic [7:0] diag_data_i,
    input  wire logic       diag_valid_i,
    // Status
    output logic            regulators_on_o,
    output logic            core_reset_o,
    output logic [2:0]      power_state_o,
    output logic            scan_mode_o,
    output logic            diag_busy_o
);
    typedef enum logic [2:0] {
        PS_OFF     = 3'b000,
        PS_SLEEP   = 3'b001,
        PS_SAVE    = 3'b010,
        PS_CHECK   = 3'b011,
        PS_FETCH   = 3'b100,
        PS_RX_ON   = 3'b101,
        PS_TX_ON   = 3'b110,
        PS_STANDBY = 3'b111
    } wmhp_ps_e;

    typedef struct packed {
        logic [2:0]  cs_s;  logic [2:0] sck_s; logic [2:0] sdi_s; logic [2:0] off_s;
        logic [2:0]  rst_s;
        logic        cs_q;  logic       sck_q;
        logic [7:0]  shin;  logic [7:0] shout; logic [2:0] bitn;
        logic        sdo;   logic       sdo_oe_n;
        logic        tx_v;  logic [7:0] tx_d;
        logic        irq_oe_n;
        wmhp_ps_e    ps;
        logic        reg_on; logic      core_rst;
        logic        scan;
        logic [15:0] bcnt; logic [3:0]  ubit; logic [9:0] ush; logic utx; logic ubusy;
    } wmhp_dev_s;

    wmhp_dev_s  st_r;
    wmhp_dev_s  st_nxt;
    logic       q_valid;
    logic [7:0] q_data;
    logic       q_pop;

    // Bytes from the radio queue for the host
    wmhp_fifo #(.WIDTH(8), .DEPTH(wmhp_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_data_i),
        .out_valid_o (q_valid),
        .out_ready_i (q_pop),
        .out_data_o  (q_data)
    );

    // Agreed-sample helpers
    function automatic logic agreed(input logic [2:0] s);
        agreed = s[2];
    endfunction

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb
    begin
        logic cs_n;
        logic sck;
        logic sck_rise;
        logic sck_fall;
        logic sel;
        cs_n     = 1'b1;
        sck      = 1'b0;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        sel      = 1'b0;
        st_nxt   = st_r;
        q_pop    = 1'b0;
        st_nxt.tx_v = 1'b0;
        // Three-stage sampling; chip select and clock accepted when stages two and three agree
        st_nxt.cs_s  = {st_r.cs_s[1:0],  pins.cs_n};
        st_nxt.sck_s = {st_r.sck_s[1:0], pins.sck};
        st_nxt.sdi_s = {st_r.sdi_s[1:0], pins.sdi};
        st_nxt.off_s = {st_r.off_s[1:0], pins.power_off_req};
        st_nxt.rst_s = {st_r.rst_s[1:0], pins.module_reset_n};
        if (st_r.cs_s[2] == st_r.cs_s[1])
        begin
            st_nxt.cs_q = agreed(st_r.cs_s);
        end
        if (st_r.sck_s[2] == st_r.sck_s[1])
        begin
            st_nxt.sck_q = agreed(st_r.sck_s);
        end
        cs_n     = st_nxt.cs_q;
        sck      = st_nxt.sck_q;
        sel      = !cs_n;
        sck_rise = sel && !st_r.cs_q && sck && !st_r.sck_q;
        sck_fall = sel && !st_r.cs_q && !sck && st_r.sck_q;

        // Serial port framing
        if (st_r.cs_q && !cs_n)
        begin
            st_nxt.bitn     = '0;
            st_nxt.shout    = q_valid ? q_data : wmhp_pkg::BYTE_IDLE;
            st_nxt.sdo      = q_valid ? q_data[7] : 1'b0;
            st_nxt.sdo_oe_n = 1'b0;
        end
        else if (!sel)
        begin
            st_nxt.sdo_oe_n = 1'b1;
        end
        if (sck_rise)
        begin
            st_nxt.shin = {st_r.shin[6:0], agreed(st_r.sdi_s)};
            st_nxt.bitn = st_r.bitn + 3'h1;
            if (st_r.bitn == wmhp_pkg::BIT_TOP)
            begin
                st_nxt.tx_v = 1'b1;
                st_nxt.tx_d = {st_r.shin[6:0], agreed(st_r.sdi_s)};
                q_pop       = q_valid;
            end
        end
        // Mode 0 and 3 both shift out on the falling edge
        if (sck_fall)
        begin
            if (st_r.bitn == 3'h0)
            begin
                st_nxt.shout = q_valid ? q_data : wmhp_pkg::BYTE_IDLE;
            end
            else
            begin
                st_nxt.shout = {st_r.shout[6:0], 1'b0};
            end
            st_nxt.sdo = (st_r.bitn == 3'h0) ? (q_valid ? q_data[7] : 1'b0)
                                             : st_r.shout[6];
        end
        st_nxt.irq_oe_n = !(q_valid && !q_pop);

        // Power states
        st_nxt.scan = pins.scan_enable && pins.boundary_scan_reset;
        if (agreed(st_r.off_s) || !supply_good_i)
        begin
            st_nxt.ps       = PS_OFF;
            st_nxt.reg_on   = !agreed(st_r.off_s) ? 1'b1 : 1'b0;
            st_nxt.core_rst = 1'b1;
        end
        else
        begin
            st_nxt.reg_on   = 1'b1;
            st_nxt.core_rst = !agreed(st_r.rst_s);
            case (st_r.ps)
                PS_OFF:     st_nxt.ps = st_r.core_rst ? PS_OFF : PS_STANDBY;
                PS_STANDBY: st_nxt.ps = radio_busy_i ? (tx_active_i ? PS_TX_ON : PS_RX_ON)
                                                     : PS_SLEEP;
                PS_RX_ON,
                PS_TX_ON:   st_nxt.ps = radio_busy_i ? (tx_active_i ? PS_TX_ON : PS_RX_ON)
                                                     : PS_STANDBY;
                PS_SLEEP:   st_nxt.ps = radio_busy_i ? PS_STANDBY
                                      : (power_save_en_i ? PS_SAVE : PS_SLEEP);
                PS_SAVE:    st_nxt.ps = beacon_tick_i ? PS_CHECK : PS_SAVE;
                PS_CHECK:   st_nxt.ps = traffic_queued_i ? PS_FETCH : PS_SAVE;
                PS_FETCH:   st_nxt.ps = rx_valid_i ? PS_SLEEP : PS_FETCH;
                default:    st_nxt.ps = PS_OFF;
            endcase
            if (st_r.core_rst)
            begin
                st_nxt.ps = PS_OFF;
            end
        end

        // Diag UART transmitter, 8N1 with no flow control
        if (!st_r.ubusy)
        begin
            if (diag_valid_i)
            begin
                st_nxt.ush   = {1'b1, diag_data_i, 1'b0};
                st_nxt.ubit  = 4'h0;
                st_nxt.bcnt  = 16'((wmhp_pkg::BAUD_CYC) - 1);
                st_nxt.ubusy = 1'b1;
                st_nxt.utx   = 1'b0;
            end
        end
        else if (st_r.bcnt != 16'h0)
        begin
            st_nxt.bcnt = st_r.bcnt - 16'h1;
        end
        else if (st_r.ubit == 4'h9)
        begin
            st_nxt.ubusy = 1'b0;
            st_nxt.utx   = 1'b1;
        end
        else
        begin
            st_nxt.ubit = st_r.ubit + 4'h1;
            st_nxt.ush  = {1'b1, st_r.ush[9:1]};
            st_nxt.utx  = st_r.ush[1];
            st_nxt.bcnt = 16'((wmhp_pkg::BAUD_CYC) - 1);
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r          <= '0;
            st_r.cs_s     <= 3'h7;
            st_r.off_s    <= 3'h7;
            st_r.cs_q     <= 1'b1;
            st_r.sdo_oe_n <= 1'b1;
            st_r.irq_oe_n <= 1'b1;
            st_r.core_rst <= 1'b1;
            st_r.utx      <= 1'b1;
            st_r.ush      <= 10'h3ff;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    assign pins.sdo          = st_r.sdo;
    assign pins.sdo_oe_n     = st_r.sdo_oe_n;
    assign pins.irq_n_oe_n   = st_r.irq_oe_n;
    assign pins.diag_uart_tx = st_r.utx;
    assign tx_valid_o        = st_r.tx_v;
    assign tx_data_o         = st_r.tx_d;
    assign regulators_on_o   = st_r.reg_on;
    assign core_reset_o      = st_r.core_rst;
    assign power_state_o     = st_r.ps;
    assign scan_mode_o       = st_r.scan;
    assign diag_busy_o       = st_r.ubusy;
endmodule

// ==== rtl/wmhp_host.sv ====
// Host controller end: power-up sequence and SPI master
`timescale 1ns/100ps
module wmhp_host #(
    parameter int unsigned SETTLE_CYC    = wmhp_pkg::SETTLE_CYC,
    parameter int unsigned RESET_REL_CYC = wmhp_pkg::RESET_REL_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    // Module pins
    wmhp_if.host            pins,
    // Control
    input  wire logic       power_up_i,      // Level: keep module powered
    input  wire logic       mode3_i,         // Clock idles high when set
    input  wire logic       scan_req_i,      // Boundary scan wanted
    input  wire logic       xfer_valid_i,    // Byte to send
    input  wire logic [7:0] xfer_data_i,
    output logic            xfer_ready_o,
    output logic            rd_valid_o,      // Byte received
    output logic [7:0]      rd_data_o,
    output logic            ready_o,         // Startup complete
    output logic            data_avail_o     // Interrupt line seen low
);
    typedef enum logic [2:0] {
        HS_OFF    = 3'b000,
        HS_SETTLE = 3'b001,
        HS_RELEAS = 3'b010,
        HS_IDLE   = 3'b011,
        HS_SHIFT  = 3'b100,
        HS_END    = 3'b101
    } wmhp_hs_e;

    typedef struct packed {
        wmhp_hs_e    hs;
        logic [31:0] cnt;
        logic        cs_n;   logic       sck;   logic [7:0] sh;  logic [7:0] rx;
        logic [3:0]  edges;  logic [7:0] half;
        logic        off;    logic       rst_n; logic       scan;
        logic        rdy;    logic       rd_v;  logic [7:0] rd_d;
        logic        xrdy;   logic [2:0] irq_s; logic       irq_q; logic [2:0] sdo_s;
    } wmhp_host_s;

    wmhp_host_s st_r;
    wmhp_host_s st_nxt;

    always_comb
    begin
        logic rising;
        rising = 1'b0;
        st_nxt = st_r;
        st_nxt.rd_v  = 1'b0;
        st_nxt.xrdy  = 1'b0;
        st_nxt.irq_s = {st_r.irq_s[1:0], pins.irq_n};
        st_nxt.sdo_s = {st_r.sdo_s[1:0], pins.sdo};
        if (st_r.irq_s[2] == st_r.irq_s[1])
        begin
            st_nxt.irq_q = st_r.irq_s[2];
        end
        // Boundary scan only while not running normally
        st_nxt.scan = scan_req_i && (st_r.hs == HS_OFF);
        case (st_r.hs)
            HS_OFF:
            begin
                st_nxt.off   = 1'b1;
                st_nxt.rst_n = 1'b0;
                st_nxt.cs_n  = 1'b1;
                st_nxt.sck   = mode3_i;
                if (power_up_i && !scan_req_i)
                begin
                    st_nxt.off = 1'b0;
                    st_nxt.cnt = 32'(SETTLE_CYC);
                    st_nxt.hs  = HS_SETTLE;
                end
            end
            HS_SETTLE:
            begin
                st_nxt.cnt = st_r.cnt - 32'h1;
                if (st_r.cnt == 32'h1)
                begin
                    st_nxt.rst_n = 1'b1;
                    st_nxt.cnt   = 32'(RESET_REL_CYC);
                    st_nxt.hs    = HS_RELEAS;
                end
            end
            HS_RELEAS:
            begin
                st_nxt.cnt = st_r.cnt - 32'h1;
                if (st_r.cnt == 32'h1)
                begin
                    st_nxt.rdy = 1'b1;
                    st_nxt.hs  = HS_IDLE;
                end
            end
            HS_IDLE:
            begin
                st_nxt.sck = mode3_i;
                if (!power_up_i)
                begin
                    st_nxt.rdy = 1'b0;
                    st_nxt.hs  = HS_OFF;
                end
                else if (xfer_valid_i)
                begin
                    st_nxt.xrdy  = 1'b1;
                    st_nxt.cs_n  = 1'b0;
                    st_nxt.sh    = xfer_data_i;
                    st_nxt.edges = 4'h0;
                    st_nxt.half  = 8'(wmhp_pkg::SCK_HALF_CYC);
                    st_nxt.hs    = HS_SHIFT;
                end
            end
            HS_SHIFT:
            begin
                // Half period kept at or above the shortest allowed
                st_nxt.half = st_r.half - 8'h1;
                if (st_r.half == 8'h1)
                begin
                    st_nxt.half  = 8'(wmhp_pkg::SCK_HALF_CYC);
                    st_nxt.sck   = !st_r.sck;
                    st_nxt.edges = st_r.edges + 4'h1;
                    // Both modes sample on the rise and shift on the fall;
                    // the first fall of mode 3 keeps the top bit on the line
                    rising = !st_r.sck;
                    if (!rising && !(mode3_i && (st_r.edges == 4'h0)))
                    begin
                        st_nxt.sh = {st_r.sh[6:0], 1'b0};
                    end
                    if (rising)
                    begin
                        st_nxt.rx = {st_r.rx[6:0], st_r.sdo_s[2]};
                    end
                    if (st_r.edges == 4'hf)
                    begin
                        st_nxt.hs = HS_END;
                    end
                end
            end
            HS_END:
            begin
                st_nxt.cs_n = 1'b1;
                st_nxt.rd_v = 1'b1;
                st_nxt.rd_d = st_r.rx;
                st_nxt.hs   = HS_IDLE;
            end
            default: st_nxt.hs = HS_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r       <= '0;
            st_r.off   <= 1'b1;
            st_r.cs_n  <= 1'b1;
            st_r.irq_s <= 3'h7;
            st_r.irq_q <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Pins and status straight from state; the diag UART receive pin is tied high
    assign pins.cs_n                = st_r.cs_n;
    assign pins.sck                 = st_r.sck;
    assign pins.sdi                 = st_r.sh[7];
    assign pins.power_off_req       = st_r.off;
    assign pins.module_reset_n      = st_r.rst_n;
    assign pins.scan_enable         = st_r.scan;
    assign pins.boundary_scan_reset = st_r.scan;
    assign pins.diag_uart_rx        = 1'b1;
    assign xfer_ready_o             = st_r.xrdy;
    assign rd_valid_o               = st_r.rd_v;
    assign rd_data_o                = st_r.rd_d;
    assign ready_o                  = st_r.rdy;
    assign data_avail_o             = !st_r.irq_q;
endmodule

// ==== tb/wmhp_checker.sv ====
// Wire-level checks on the host/module pin bundle
`timescale 1ns/100ps
module wmhp_checker #(
    parameter int unsigned SETTLE_CYC = 20
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdo_oe_n,
    input wire logic power_off_req,
    input wire logic module_reset_n,
    input wire logic scan_enable,
    input wire logic boundary_scan_reset,
    input wire logic diag_uart_tx
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic [31:0] settle_r;
    // Cycles since power-off release; the settle wait is judged against it
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            settle_r <= 32'h0;
        end
        else if (power_off_req)
        begin
            settle_r <= 32'h0;
        end
        else
        begin
            settle_r <= settle_r + 32'h1;
        end
    end
    a_cs_high_off: assert property (power_off_req |-> cs_n) else $error("cs low while off");
    a_reset_after_on: assert property (module_reset_n |-> !power_off_req)
        else $error("reset released while off");
    a_settle_wait: assert property ($rose(module_reset_n) |-> settle_r >= SETTLE_CYC - 1)
        else $error("reset released too early");
    a_sck_half: assert property ($changed(sck) && !cs_n |=> $stable(sck))
        else $error("sck half period too short");
    a_sck_quiet_cs: assert property ($fell(cs_n) |-> $stable(sck))
        else $error("sck moved at cs fall");
    a_oe_released: assert property (cs_n [*8] |-> sdo_oe_n) else $error("sdo driven");
    a_scan_when_off: assert property (scan_enable && boundary_scan_reset |-> power_off_req)
        else $error("scan during operation");
    a_start_bit: assert property ($fell(diag_uart_tx) |-> !diag_uart_tx [*8])
        else $error("short start bit");
endmodule

// ==== tb/wireless_module_host_port_test.sv ====
// Self-checking bench joining host and module ends
`timescale 1ns/100ps
module wireless_module_host_port_test;
    logic       clk_sys_i = 1'b0;
    logic       resetn_i  = 1'b0;
    logic       pw = 1'b0, m3 = 1'b0, scn = 1'b0, xv = 1'b0, sup = 1'b0, rxv = 1'b0;
    logic       ps_en = 1'b0, tick_b = 1'b0, tq = 1'b0, txa = 1'b0, dv = 1'b0, bsy = 1'b0;
    logic [7:0] xd = 8'h00, rxd = 8'h00, dd = 8'h00, last_tx, b;
    logic       xr, rv, rdy, av, rxr, txv, regs_on, core_rst, scan_m, dbusy;
    logic [7:0] rdd, txd;
    logic [2:0] pst;
    int         errors = 0;
    int         n_checks = 0;
    wmhp_if pins_if();
    wmhp_host #(.SETTLE_CYC(20), .RESET_REL_CYC(50)) i_wmhp_host (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .pins(pins_if.host), .power_up_i(pw), .mode3_i(m3),
        .scan_req_i(scn), .xfer_valid_i(xv), .xfer_data_i(xd), .xfer_ready_o(xr),
        .rd_valid_o(rv), .rd_data_o(rdd), .ready_o(rdy), .data_avail_o(av));
    wmhp_device i_wmhp_device (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .supply_good_i(sup), .pins(pins_if.device), .rx_valid_i(rxv), .rx_data_i(rxd),
        .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd), .power_save_en_i(ps_en),
        .beacon_tick_i(tick_b), .traffic_queued_i(tq), .radio_busy_i(bsy),
        .tx_active_i(txa), .diag_data_i(dd), .diag_valid_i(dv), .regulators_on_o(regs_on),
        .core_reset_o(core_rst), .power_state_o(pst), .scan_mode_o(scan_m),
        .diag_busy_o(dbusy));
    wmhp_checker #(.SETTLE_CYC(20)) i_wmhp_checker (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .cs_n(pins_if.cs_n), .sck(pins_if.sck),
        .sdo_oe_n(pins_if.sdo_oe_n), .power_off_req(pins_if.power_off_req),
        .module_reset_n(pins_if.module_reset_n), .scan_enable(pins_if.scan_enable),
        .boundary_scan_reset(pins_if.boundary_scan_reset),
        .diag_uart_tx(pins_if.diag_uart_tx));
    // Free-running system clock
    always #5 clk_sys_i = ~clk_sys_i;
    // Keep the last byte the module received, since its strobe is one cycle
    always @(posedge clk_sys_i)
    begin
        if (txv === 1'b1)
            last_tx <= txd;
    end
    task cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Bounded wait, so a stuck state machine shows as a mismatch
    task state_is(input logic [2:0] s);
        int k;
        k = 0;
        while (pst !== s && k < 3000)
        begin
            cyc(1);
            k++;
        end
        chk(pst, s);
    endtask
    task push(input logic [7:0] d);
        rxv = 1'b1;
        rxd = d;
        while (rxr !== 1'b1)
            cyc(1);
        cyc(1);
        rxv = 1'b0;
        cyc(1);
    endtask
    task xfer(input logic [7:0] d, input logic [7:0] exp);
        xv = 1'b1;
        xd = d;
        cyc(1);
        while (xr !== 1'b1)
            cyc(1);
        xv = 1'b0;
        while (rv !== 1'b1)
            cyc(1);
        chk(rdd, exp);
        cyc(8);
        chk(last_tx, d);
    endtask
    // Main sequence
    initial
    begin
        cyc(20);
        resetn_i = 1'b1;
        cyc(5);
        chk(core_rst, 1'b1);
        pw = 1'b1;
        sup = 1'b1;
        while (rdy !== 1'b1)
            cyc(1);
        chk(regs_on, 1'b1);
        chk(core_rst, 1'b0);
        $display("test power_up done");
        for (int i = 0; i < 4; i++)
            push(8'h30 | 8'(i));
        chk(rxr, 1'b0);
        cyc(8);
        chk(av, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            m3 = i[0];
            cyc(4);
            xfer(8'ha0 | 8'(i), 8'h30 | 8'(i));
        end
        xfer(8'h5a, wmhp_pkg::BYTE_IDLE);
        cyc(8);
        chk(pins_if.irq_n, 1'b1);
        chk(pins_if.sdo_oe_n, 1'b1);
        $display("test spi done");
        ps_en = 1'b1;
        state_is(3'h2);
        tick_b = 1'b1;
        cyc(1);
        tick_b = 1'b0;
        state_is(3'h3);
        state_is(3'h2);
        tq = 1'b1;
        tick_b = 1'b1;
        cyc(1);
        tick_b = 1'b0;
        state_is(3'h4);
        tq = 1'b0;
        ps_en = 1'b0;
        push(8'h77);
        state_is(3'h1);
        cyc(8);
        chk(av, 1'b1);
        xfer(8'h11, 8'h77);
        bsy = 1'b1;
        state_is(3'h5);
        txa = 1'b1;
        state_is(3'h6);
        txa = 1'b0;
        bsy = 1'b0;
        state_is(3'h1);
        $display("test power_states done");
        dd = 8'h96;
        dv = 1'b1;
        cyc(1);
        dv = 1'b0;
        while (pins_if.diag_uart_tx === 1'b1)
            cyc(1);
        cyc(wmhp_pkg::BAUD_CYC / 2);
        chk(pins_if.diag_uart_tx, 1'b0);
        chk(dbusy, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            cyc(wmhp_pkg::BAUD_CYC);
            b[i] = pins_if.diag_uart_tx;
        end
        cyc(wmhp_pkg::BAUD_CYC);
        chk(pins_if.diag_uart_tx, 1'b1);
        chk(b, 8'h96);
        $display("test uart done");
        pw = 1'b0;
        state_is(3'h0);
        chk(regs_on, 1'b0);
        chk(pins_if.cs_n, 1'b1);
        scn = 1'b1;
        cyc(10);
        chk(scan_m, 1'b1);
        $display("test off_scan done");
        stop_test;
    end
    // Watchdog: the whole sequence needs about 51000 cycles
    initial
    begin
        cyc(90000);
        errors++;
        stop_test;
    end
endmodule
